// file: sto_cfg.svh
`ifndef STO_CFG_SVH
`define STO_CFG_SVH

// register addresses on the serial register port
`define STO_ADDR_DIV    7'h59
`define STO_ADDR_VCUR   7'h5a
`define STO_ADDR_VCAL   7'h5b
`define STO_ADDR_SYN    7'h5c
`define STO_ADDR_OVR1   7'h5d
`define STO_ADDR_OVR2   7'h5e
`define STO_ADDR_OVR3   7'h5f
`define STO_ADDR_CIDX   7'h60
`define STO_ADDR_CDAT   7'h61

// reset values
`define STO_RST_DIV     8'h80
`define STO_RST_VCUR    8'h00
`define STO_RST_SYN     8'h0e
`define STO_RST_OVR     8'h00
`define STO_RST_ZERO8   8'h00

// field positions
`define STO_DIV_HC      6
`define STO_DIV_D3      5:4
`define STO_DIV_D2      3:2
`define STO_DIV_D15     1:0
`define STO_VCUR_OV     6
`define STO_VCUR_CORR   5:2
`define STO_VCUR_CUR    1:0
`define STO_VCAL_FLAG   7
`define STO_VCAL_VAL    6:0
`define STO_SYN_DITH    7
`define STO_SYN_TYPE    6
`define STO_SYN_OLOOP   5
`define STO_SYN_MOD     4
`define STO_SYN_ORDER   3:2
`define STO_SYN_RMODE   1
`define STO_SYN_RST     0
`define STO_OVR2_LDET   6
`define STO_CIDX_IDX    3:0
`define STO_CDAT_VAL    5:0
`define STO_CDAT_RSV    7:6

// modulus values and block mask (bit 6 of override two and bit 4 of override one are not blocks)
`define STO_MOD_LOW     17'h0fa00
`define STO_MOD_HIGH    17'h10000
`define STO_BLK_MASK    24'hffbfef
`define STO_COEF_DEPTH  16

`endif

// file: sto_pkg.sv
package sto_pkg;
    typedef enum logic [1:0] {
        STO_ORDER_ZERO,
        STO_ORDER_FIRST,
        STO_ORDER_SECOND,
        STO_ORDER_MASH
    } sto_ds_order_t;
    typedef logic [6:0] sto_addr_t;
    typedef logic [7:0] sto_byte_t;
endpackage : sto_pkg

// file: sto_wr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sto_wr_if;
    logic              wr;
    sto_pkg::sto_addr_t addr;
    sto_pkg::sto_byte_t wdata;
    modport src (output wr, output addr, output wdata);
    modport dst (input wr, input addr, input wdata);
endinterface : sto_wr_if
`default_nettype wire

// file: sto_vcocal.sv
`timescale 1ns/1ps
`default_nettype none
`include "sto_cfg.svh"
module sto_vcocal (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // register writes
    sto_wr_if.dst                  bus,
    // internal calibration engine
    input  wire logic [6:0]        cal_result,
    input  wire logic              cal_done,
    // read value and applied code
    output logic [7:0]             cal_rdata,
    output logic [6:0]             cal_code_r
);
    import sto_pkg::*;

    logic       ovr_r;
    logic [6:0] ovr_val_r;
    logic       wr_hit;

    assign wr_hit = bus.wr && (bus.addr == `STO_ADDR_VCAL);
    // bit 7 reads back the done flag, never the override setting
    assign cal_rdata = {cal_done, cal_code_r};

    // the value field is taken only while the override already stands, so a
    // single write cannot both arm the override and load a code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovr_r     <= 1'b0;
            ovr_val_r <= 7'h00;
        end else if (wr_hit) begin
            ovr_r <= bus.wdata[`STO_VCAL_FLAG];
            if (ovr_r) begin
                ovr_val_r <= bus.wdata[`STO_VCAL_VAL];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_code_r <= 7'h00;
        end else begin
            cal_code_r <= ovr_r ? ovr_val_r : cal_result;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    cal_follow_a: assert property (!ovr_r |=> cal_code_r == $past(cal_result))
        else $error("calibration code does not follow internal result");
    cal_replace_a: assert property (ovr_r && wr_hit ##1 ovr_r |=> cal_code_r == $past(bus.wdata[6:0], 2))
        else $error("override code not applied");
endmodule : sto_vcocal
`default_nettype wire

// file: sto_coef.sv
`timescale 1ns/1ps
`default_nettype none
`include "sto_cfg.svh"
module sto_coef (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // register writes
    sto_wr_if.dst                  bus,
    // read values
    output logic [7:0]             idx_rdata,
    output logic [7:0]             dat_rdata,
    // channel filter tap port
    input  wire logic [3:0]        tap_index,
    output logic [5:0]             tap_coef_r
);
    import sto_pkg::*;

    logic [7:0] idx_r;
    logic [1:0] dat_rsv_r;
    logic [5:0] table_r [`STO_COEF_DEPTH];
    logic       wr_idx;
    logic       wr_dat;
    logic [3:0] sel;

    assign wr_idx    = bus.wr && (bus.addr == `STO_ADDR_CIDX);
    assign wr_dat    = bus.wr && (bus.addr == `STO_ADDR_CDAT);
    assign sel       = idx_r[`STO_CIDX_IDX];
    assign idx_rdata = idx_r;
    assign dat_rdata = {dat_rsv_r, table_r[sel]};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_r     <= `STO_RST_ZERO8;
            dat_rsv_r <= 2'h0;
        end else begin
            if (wr_idx) idx_r <= bus.wdata;
            if (wr_dat) dat_rsv_r <= bus.wdata[`STO_CDAT_RSV];
        end
    end

    generate
        for (genvar i = 0; i < `STO_COEF_DEPTH; i++) begin : g_entry
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    table_r[i] <= 6'h00;
                end else if (wr_dat && (sel == 4'(i))) begin
                    table_r[i] <= bus.wdata[`STO_CDAT_VAL];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) tap_coef_r <= 6'h00;
        else     tap_coef_r <= table_r[tap_index];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    coef_index_a: assert property (wr_idx |=> sel == $past(bus.wdata[3:0]))
        else $error("coefficient index not stored");
    coef_store_a: assert property (wr_dat ##1 !wr_idx |-> dat_rdata[5:0] == $past(bus.wdata[5:0]))
        else $error("coefficient entry not stored at index");
endmodule : sto_coef
`default_nettype wire

// file: sto_regs.sv
// What this block does
// - divider trim resets to 0x80; bit 6 extra current, three 2-bit trims
// - vco current: bit 6 override, bits 5:2 correction, bits 1:0 trim
// - without override, calibration field reads the internal calibration result
// - with override already set, a calibration value written with bit 7 set replaces the internal result
// - calibration register bit 7 reads the calibration done flag
// - synth test bit 7 enables dithering; bit 6 reads vco type
// - bit 4 picks modulus 64000 or 65536; bits 3:2 pick order
// - synth test bit 5 open loop, bit 1 reset mode, bit 0 reset
// - synth test resets to 0x0e with bit 6 the live vco type
// - override one: mixer, lna, pga, buffer5, div3_2, buffer1_2, mux2
// - override two bit 6 drives lock detect directly
// - override two: modulator, mux3, buffers 4,3,1_1,2 and pll reset
// - override three: frac div, dividers, shunt, vco, charge pump, bandgap
// - coefficient address bits 3:0 select the filter table entry
// - data register bits 5:0 expose the selected coefficient
// - global override lets bits force off; otherwise they only force on
`timescale 1ns/1ps
`default_nettype none
`include "sto_cfg.svh"
module sto_regs (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // serial register port, already deserialised
    input  wire logic                  reg_wr_en,
    input  wire logic                  reg_rd_en,
    input  wire sto_pkg::sto_addr_t    reg_addr,
    input  wire sto_pkg::sto_byte_t    reg_wdata,
    output logic [7:0]                 reg_rdata,
    output logic                       reg_rvalid,
    // calibration engine and analog status
    input  wire logic [6:0]            vco_cal_result,
    input  wire logic                  vco_cal_done,
    input  wire logic                  vco_type_pin,
    // block enable sources
    input  wire logic                  ovr_global_en,
    input  wire logic [23:0]           sm_block_en,
    // divider and vco trims
    output logic                       fb_div_high_current,
    output logic [1:0]                 div_three_trim,
    output logic [1:0]                 div_two_trim,
    output logic [1:0]                 div_one_half_trim,
    output logic                       vco_corr_ovr,
    output logic [3:0]                 vco_corr_val,
    output logic [1:0]                 vco_cur_trim,
    output logic [6:0]                 vco_cal_code,
    // delta-sigma modulator
    output logic                       dsm_dither_en,
    output logic                       open_loop_en,
    output logic [16:0]                dsm_modulus,
    output sto_pkg::sto_ds_order_t     dsm_order,
    output logic                       dsm_rst_mode,
    output logic                       dsm_rst,
    // block enables
    output logic [23:0]                block_en,
    output logic                       lock_detect_en,
    // channel filter tap port
    input  wire logic [3:0]            tap_index,
    output logic [5:0]                 tap_coef
);
    import sto_pkg::*;

    // ****************************************************************
    // storage and decode
    // ****************************************************************
    logic [7:0]  div_r;
    logic [7:0]  vcur_r;
    logic [7:0]  syn_r;
    logic [7:0]  ovr1_r;
    logic [7:0]  ovr2_r;
    logic [7:0]  ovr3_r;
    logic [16:0] modulus_r;
    logic [23:0] block_en_r;
    logic [23:0] block_en_nxt;
    logic [23:0] blk_mask;
    logic [7:0]  rdata_r;
    logic        rvalid_r;
    logic        type_s1_r;
    logic        type_s2_r;

    logic        wr_div;
    logic        wr_vcur;
    logic        wr_syn;
    logic        wr_ovr1;
    logic        wr_ovr2;
    logic        wr_ovr3;
    logic        rd_hit;
    logic [7:0]  rd_mux;
    logic [7:0]  syn_rd;
    logic [23:0] ovr_all;
    logic [7:0]  cal_rdata;
    logic [7:0]  idx_rdata;
    logic [7:0]  dat_rdata;
    logic [6:0]  cal_code_r;
    logic [5:0]  tap_coef_r;

    sto_wr_if wbus ();
    assign wbus.wr    = reg_wr_en;
    assign wbus.addr  = reg_addr;
    assign wbus.wdata = reg_wdata;

    assign wr_div  = reg_wr_en && (reg_addr == `STO_ADDR_DIV);
    assign wr_vcur = reg_wr_en && (reg_addr == `STO_ADDR_VCUR);
    assign wr_syn  = reg_wr_en && (reg_addr == `STO_ADDR_SYN);
    assign wr_ovr1 = reg_wr_en && (reg_addr == `STO_ADDR_OVR1);
    assign wr_ovr2 = reg_wr_en && (reg_addr == `STO_ADDR_OVR2);
    assign wr_ovr3 = reg_wr_en && (reg_addr == `STO_ADDR_OVR3);

    // ****************************************************************
    // submodules
    // ****************************************************************
    sto_vcocal u_vcocal (
        .clk        (clk),
        .rst        (rst),
        .bus        (wbus),
        .cal_result (vco_cal_result),
        .cal_done   (vco_cal_done),
        .cal_rdata  (cal_rdata),
        .cal_code_r (cal_code_r)
    );

    sto_coef u_coef (
        .clk        (clk),
        .rst        (rst),
        .bus        (wbus),
        .idx_rdata  (idx_rdata),
        .dat_rdata  (dat_rdata),
        .tap_index  (tap_index),
        .tap_coef_r (tap_coef_r)
    );

    // ****************************************************************
    // vco type synchroniser
    // ****************************************************************
    // the type strap is analog and asynchronous, so it is read only after two flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            type_s1_r <= 1'b0;
            type_s2_r <= 1'b0;
        end else begin
            type_s1_r <= vco_type_pin;
            type_s2_r <= type_s1_r;
        end
    end

    // ****************************************************************
    // trim and test registers
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r  <= `STO_RST_DIV;
            vcur_r <= `STO_RST_VCUR;
        end else begin
            if (wr_div)  div_r  <= reg_wdata;
            if (wr_vcur) vcur_r <= reg_wdata;
        end
    end

    // the vco type bit is never stored; it is substituted on read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syn_r <= `STO_RST_SYN;
        end else if (wr_syn) begin
            syn_r <= {reg_wdata[`STO_SYN_DITH], 1'b0, reg_wdata[`STO_SYN_OLOOP:`STO_SYN_RST]};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modulus_r <= `STO_MOD_LOW;
        end else begin
            modulus_r <= syn_r[`STO_SYN_MOD] ? `STO_MOD_HIGH : `STO_MOD_LOW;
        end
    end

    // ****************************************************************
    // block enable overrides
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovr1_r <= `STO_RST_OVR;
            ovr2_r <= `STO_RST_OVR;
            ovr3_r <= `STO_RST_OVR;
        end else begin
            if (wr_ovr1) ovr1_r <= reg_wdata;
            if (wr_ovr2) ovr2_r <= reg_wdata;
            if (wr_ovr3) ovr3_r <= reg_wdata;
        end
    end

    assign ovr_all  = {ovr3_r, ovr2_r, ovr1_r};
    // lock detect and the reserved bit are not block enables, so the mask keeps them at zero
    assign blk_mask = `STO_BLK_MASK;

    // without the global enable an override bit can only add to the state machine's enables
    generate
        for (genvar i = 0; i < 24; i++) begin : g_blk
            assign block_en_nxt[i] = blk_mask[i] &&
                                     (ovr_global_en ? ovr_all[i] : (ovr_all[i] || sm_block_en[i]));
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    block_en_r[i] <= 1'b0;
                end else begin
                    block_en_r[i] <= block_en_nxt[i];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // read path
    // ****************************************************************
    assign syn_rd = {syn_r[`STO_SYN_DITH], type_s2_r, syn_r[`STO_SYN_OLOOP:`STO_SYN_RST]};
    assign rd_hit = (reg_addr >= `STO_ADDR_DIV) && (reg_addr <= `STO_ADDR_CDAT);
    assign rd_mux = (reg_addr == `STO_ADDR_DIV)  ? div_r :
                    (reg_addr == `STO_ADDR_VCUR) ? vcur_r :
                    (reg_addr == `STO_ADDR_VCAL) ? cal_rdata :
                    (reg_addr == `STO_ADDR_SYN)  ? syn_rd :
                    (reg_addr == `STO_ADDR_OVR1) ? ovr1_r :
                    (reg_addr == `STO_ADDR_OVR2) ? ovr2_r :
                    (reg_addr == `STO_ADDR_OVR3) ? ovr3_r :
                    (reg_addr == `STO_ADDR_CIDX) ? idx_rdata :
                    (reg_addr == `STO_ADDR_CDAT) ? dat_rdata :
                    `STO_RST_ZERO8;

    // addresses outside this bank answer zero so another bank can be or-ed in
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r  <= `STO_RST_ZERO8;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd_en;
            if (reg_rd_en) rdata_r <= rd_hit ? rd_mux : `STO_RST_ZERO8;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata           = rdata_r;
    assign reg_rvalid          = rvalid_r;
    assign fb_div_high_current = div_r[`STO_DIV_HC];
    assign div_three_trim      = div_r[`STO_DIV_D3];
    assign div_two_trim        = div_r[`STO_DIV_D2];
    assign div_one_half_trim   = div_r[`STO_DIV_D15];
    assign vco_corr_ovr        = vcur_r[`STO_VCUR_OV];
    assign vco_corr_val        = vcur_r[`STO_VCUR_CORR];
    assign vco_cur_trim        = vcur_r[`STO_VCUR_CUR];
    assign vco_cal_code        = cal_code_r;
    assign dsm_dither_en       = syn_r[`STO_SYN_DITH];
    assign open_loop_en        = syn_r[`STO_SYN_OLOOP];
    assign dsm_modulus         = modulus_r;
    assign dsm_order           = sto_ds_order_t'(syn_r[`STO_SYN_ORDER]);
    assign dsm_rst_mode        = syn_r[`STO_SYN_RMODE];
    assign dsm_rst             = syn_r[`STO_SYN_RST];
    assign block_en            = block_en_r;
    assign lock_detect_en      = ovr2_r[`STO_OVR2_LDET];
    assign tap_coef            = tap_coef_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence write_to(logic [6:0] a);
        reg_wr_en && reg_addr == a;
    endsequence

    sequence read_from(logic [6:0] a);
        reg_rd_en && reg_addr == a;
    endsequence

    div_write_a: assert property (write_to(`STO_ADDR_DIV) |=>
        {fb_div_high_current, div_three_trim, div_two_trim, div_one_half_trim} == $past(reg_wdata[6:0]))
        else $error("divider trim fields do not match written value");
    vcur_write_a: assert property (write_to(`STO_ADDR_VCUR) |=>
        {vco_corr_ovr, vco_corr_val, vco_cur_trim} == $past(reg_wdata[6:0]))
        else $error("vco current fields do not match written value");
    cal_done_a: assert property (read_from(`STO_ADDR_VCAL) |=>
        reg_rdata[7] == $past(vco_cal_done))
        else $error("calibration done flag not returned on bit 7");
    vco_type_a: assert property (read_from(`STO_ADDR_SYN) |=>
        reg_rdata[6] == $past(type_s2_r))
        else $error("vco type bit not returned on read");
    modulus_sel_a: assert property (write_to(`STO_ADDR_SYN) ##2 1 |->
        dsm_modulus == ($past(reg_wdata[`STO_SYN_MOD], 2) ? `STO_MOD_HIGH : `STO_MOD_LOW))
        else $error("modulus does not follow select bit");
    ldet_direct_a: assert property (write_to(`STO_ADDR_OVR2) ##1 !ovr_global_en |->
        lock_detect_en == $past(reg_wdata[6]))
        else $error("lock detect not driven directly");
    force_on_a: assert property (!ovr_global_en && ovr1_r[7] |=> block_en[7])
        else $error("override bit failed to force block on");
    force_off_a: assert property (ovr_global_en && !ovr3_r[0] |=> !block_en[16])
        else $error("override bit failed to force block off");
    read_answer_a: assert property (reg_rd_en && !rd_hit |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("unmapped read did not answer zero");

    // ****************************************************************
    // checks on stored fields
    // ****************************************************************
    // each field is held against the written byte, so a wrong slice in the store shows at once
    syn_dither_a: assert property (write_to(`STO_ADDR_SYN) |=>
        dsm_dither_en == $past(reg_wdata[`STO_SYN_DITH]))
        else $error("dither enable does not follow written bit");
    syn_order_a: assert property (write_to(`STO_ADDR_SYN) |=>
        dsm_order == sto_ds_order_t'($past(reg_wdata[`STO_SYN_ORDER])))
        else $error("modulator order does not follow written field");
    syn_ctrl_a: assert property (write_to(`STO_ADDR_SYN) |=>
        {open_loop_en, dsm_rst_mode, dsm_rst} ==
        {$past(reg_wdata[`STO_SYN_OLOOP]), $past(reg_wdata[`STO_SYN_RMODE]), $past(reg_wdata[`STO_SYN_RST])})
        else $error("open loop or reset controls do not follow written bits");
    div_rsv_a: assert property (write_to(`STO_ADDR_DIV) |=>
        div_r[7] == $past(reg_wdata[7]))
        else $error("divider trim reserved bit not stored");
    vcur_rsv_a: assert property (write_to(`STO_ADDR_VCUR) |=>
        vcur_r[7] == $past(reg_wdata[7]))
        else $error("vco current reserved bit not stored");

    ovr1_store_a: assert property (write_to(`STO_ADDR_OVR1) |=>
        ovr1_r == $past(reg_wdata))
        else $error("override one not stored");
    ovr2_store_a: assert property (write_to(`STO_ADDR_OVR2) |=>
        ovr2_r == $past(reg_wdata))
        else $error("override two not stored");
    ovr3_store_a: assert property (write_to(`STO_ADDR_OVR3) |=>
        ovr3_r == $past(reg_wdata))
        else $error("override three not stored");
    ldet_global_a: assert property (write_to(`STO_ADDR_OVR2) ##1 ovr_global_en |->
        lock_detect_en == $past(reg_wdata[6]))
        else $error("lock detect not driven directly under global override");

    rsv_block_a: assert property (!block_en[4] && !block_en[14])
        else $error("reserved or lock detect position drives a block enable");
    force_off_one_a: assert property (ovr_global_en && !ovr1_r[7] |=> !block_en[7])
        else $error("override one bit failed to force block off");
    sm_pass_a: assert property (!ovr_global_en && sm_block_en[16] |=> block_en[16])
        else $error("state machine enable lost without global override");
    cal_read_a: assert property (read_from(`STO_ADDR_VCAL) |=>
        reg_rdata[6:0] == $past(vco_cal_code))
        else $error("calibration field does not read the applied code");

    rd_answer_a: assert property (reg_rd_en |=> reg_rvalid)
        else $error("read not answered in the next cycle");
    rvalid_pulse_a: assert property (!reg_rd_en |=> !reg_rvalid)
        else $error("read answer raised without a read");
endmodule : sto_regs
`default_nettype wire

// file: sto_host_mdl.sv
`timescale 1ns/1ps
`default_nettype none
module sto_host_mdl (
    // clock
    input  wire logic          clk,
    // register port
    output logic               reg_wr_en,
    output logic               reg_rd_en,
    output sto_pkg::sto_addr_t reg_addr,
    output sto_pkg::sto_byte_t reg_wdata,
    input  wire logic [7:0]    reg_rdata,
    input  wire logic          reg_rvalid
);
    import sto_pkg::*;
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 7'h00;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse of the last value so stale data cannot match
    task automatic put(input logic wr, input sto_addr_t a, input sto_byte_t d);
        @(posedge clk);
        #1;
        reg_wr_en = wr;
        reg_rd_en = !wr;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : put
    // the answer stands one cycle, so it is taken right after the taking edge
    task automatic rd(input sto_addr_t a, output sto_byte_t d, output logic ok);
        put(1'b0, a, 8'h00);
        ok = (reg_rvalid === 1'b1);
        d  = reg_rdata;
    endtask : rd
endmodule : sto_host_mdl
`default_nettype wire

// file: test_synth_trim_override_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "sto_cfg.svh"
module test_synth_trim_override_regs;
    import sto_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cal_done = 1'b1, vtype = 1'b1, glob = 1'b1;
    logic [6:0] cal_res = 7'h2a;
    logic [23:0] sm_en = 24'h000000;
    logic [3:0] tap_idx = 4'h0;
    logic wr_en, rd_en, rvalid, hc, ovc, dith, olp, rmode, drst, ldet;
    sto_addr_t addr;
    sto_byte_t wdata;
    logic [7:0] rdata;
    logic [1:0] d3, d2, d15, cur;
    logic [3:0] corr;
    logic [6:0] code;
    logic [16:0] modu;
    sto_ds_order_t ord;
    logic [23:0] blk;
    logic [5:0] coef;
    int failures = 0;
    int n_compared = 0;
    always #2 clk = ~clk;
    sto_host_mdl sto_host_mdl_i (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));
    sto_regs sto_regs_i (.clk(clk), .rst(rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .vco_cal_result(cal_res),
        .vco_cal_done(cal_done), .vco_type_pin(vtype), .ovr_global_en(glob), .sm_block_en(sm_en),
        .fb_div_high_current(hc), .div_three_trim(d3), .div_two_trim(d2), .div_one_half_trim(d15),
        .vco_corr_ovr(ovc), .vco_corr_val(corr), .vco_cur_trim(cur), .vco_cal_code(code),
        .dsm_dither_en(dith), .open_loop_en(olp), .dsm_modulus(modu), .dsm_order(ord),
        .dsm_rst_mode(rmode), .dsm_rst(drst), .block_en(blk), .lock_detect_en(ldet),
        .tap_index(tap_idx), .tap_coef(coef));
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test;
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    // block enables land two edges after the write, so every write waits three
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic wr(input sto_addr_t a, input sto_byte_t d);
        sto_host_mdl_i.put(1'b1, a, d);
        settle();
    endtask : wr
    task automatic rdc(input sto_addr_t a, input logic [7:0] exp);
        sto_byte_t d;
        logic ok;
        sto_host_mdl_i.rd(a, d, ok);
        chk(24'(ok), 24'h000001);
        chk(24'(d), 24'(exp));
    endtask : rdc
    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        rdc(7'h59, 8'h80);
        rdc(7'h5b, 8'haa);
        rdc(7'h5c, 8'h4e);
        for (int a = 'h5d; a <= 'h60; a++) rdc(7'(a), 8'h00);
        chk(24'({modu, ord, rmode, drst, dith}), 24'h1f401c);
        rdc(7'h62, 8'h00);
    endtask : t_reset
    task automatic t_trim;
        wr(7'h59, 8'hdb);
        chk(24'({hc, d3, d2, d15}), 24'h5b);
        rdc(7'h59, 8'hdb);
        wr(7'h5a, 8'he5);
        chk(24'({ovc, corr, cur}), 24'h65);
        rdc(7'h5a, 8'he5);
    endtask : t_trim
    task automatic t_cal;
        cal_res = 7'h33;
        settle();
        rdc(7'h5b, 8'hb3);
        wr(7'h5b, 8'h80);
        wr(7'h5b, 8'h95);
        cal_res  = 7'h0f;
        cal_done = 1'b0;
        settle();
        rdc(7'h5b, 8'h15);
        chk(24'(code), 24'h15);
        wr(7'h5b, 8'h00);
        rdc(7'h5b, 8'h0f);
        chk(24'(code), 24'h0f);
        cal_done = 1'b1;
    endtask : t_cal
    task automatic t_syn;
        for (int m = 0; m < 2; m++) begin
            for (int o = 0; o < 4; o++) begin
                wr(7'h5c, {3'b101, m[0], o[1:0], 2'b01});
                chk(24'({dith, olp, rmode, drst}), 24'hd);
                chk(24'(modu), (m == 1) ? 24'h10000 : 24'h0fa00);
                chk(24'(ord), 24'(o));
            end
        end
        vtype = 1'b0;
        wr(7'h5c, 8'h42);
        chk(24'({dith, olp, rmode, drst}), 24'h2);
        rdc(7'h5c, 8'h02);
    endtask : t_syn
    task automatic t_ovr;
        sm_en = 24'hffffff;
        wr(7'h5d, 8'hb5);
        wr(7'h5e, 8'h6a);
        wr(7'h5f, 8'h3c);
        chk(blk, 24'h3c6ab5 & `STO_BLK_MASK);
        glob = 1'b0;
        settle();
        chk(blk, `STO_BLK_MASK);
        chk(24'(ldet), 24'h1);
        sm_en = 24'h000000;
        wr(7'h5e, 8'h95);
        chk(blk, 24'h3c95b5 & `STO_BLK_MASK);
        chk(24'(ldet), 24'h0);
        rdc(7'h5d, 8'hb5);
    endtask : t_ovr
    task automatic t_coef;
        wr(7'h60, 8'ha5);
        wr(7'h61, 8'hfc);
        tap_idx = 4'h5;
        settle();
        chk(24'(coef), 24'h3c);
        rdc(7'h60, 8'ha5);
        rdc(7'h61, 8'hfc);
        wr(7'h60, 8'h06);
        rdc(7'h61, 8'hc0);
        tap_idx = 4'h6;
        settle();
        chk(24'(coef), 24'h00);
    endtask : t_coef
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        settle();
        t_reset();
        t_trim();
        t_cal();
        t_syn();
        t_ovr();
        t_coef();
        finish_test();
    end
endmodule : test_synth_trim_override_regs
`default_nettype wire
